// File: rtl/ptpidx_pkg.sv
// package: offsets, field positions and reset values for the ptp unit bank
package ptpidx_pkg;
  localparam logic [11:0] OFF_INDEX = 12'h0520;
  localparam logic [11:0] OFF_DONE_ERR = 12'h0524;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h0528;
  localparam logic [11:0] OFF_STAMP_CTRL = 12'h052C;
  localparam logic [11:0] OFF_NOTIFY = 12'h05B0;
  localparam logic [11:0] OFF_INDEXED_LO = 12'h052C;
  localparam logic [11:0] OFF_INDEXED_HI = 12'h05B3;
  localparam int NUM_OEU = 3;
  localparam int NUM_ISU = 2;
  localparam int POS_STAMP_PTR = 8;
  localparam int POS_OEU_PTR = 0;
  localparam int POS_ERR = 16;
  localparam int POS_DONE = 0;
  localparam int POS_OEU_IRQ = 16;
  localparam int POS_ISU_IRQ = 0;
  localparam int POS_OEU_EN = 3;
  localparam int POS_STAMP_IRQ_EN = 5;
  localparam int POS_NOTIFY = 0;
  localparam logic [1:0] OEU_PTR_RESERVED = 2'h3;
  localparam logic [1:0] OEU_PTR_RST = 2'h0;
  localparam logic STAMP_PTR_RST = 1'b0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : ptpidx_pkg

// File: rtl/ptpidx_bank.sv
// unit index register and output-event / stamp status flags over apb
// What this block does
// - the stored index chooses which stamp and output-event unit answer accesses in the indexed range.
// - an indexed access reaches only the selected unit and leaves the others untouched.
// - the stamp-unit pointer at bit 8 selects stamp unit 1 when set, unit 0 when clear, reset zero.
// - the two-bit output-event pointer selects unit 0..2, code 11 is reserved, reset 00.
// - a unit's late-error flag in bits 18:16 sets when its target is late while notifying.
// - a late-error flag clears on a written one or when the unit enable is written to zero.
// - a notifying unit's done flag in bits 2:0 sets when its event fires and clears on a written one.
// - setting a late-error or done flag on a notifying unit raises an interrupt request.
// - the global pin-event interrupt is the or of all interrupt status bits.
// - interrupt status bits 18:16 record output-event interrupts, gated by notify, cleared by write.
// - interrupt status bits 1:0 record stamp interrupts, gated by stamp irq enable, cleared by write.
// - an output-event unit enable at bit 3 clears itself when its event is generated.
// - the per-unit stamp interrupt enable sits at bit 5 of the stamp control register.
module ptpidx_bank
  import ptpidx_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // unit events, one-cycle pulses from the unit logic
  input wire logic [NUM_OEU-1:0] oeu_fired,
  input wire logic [NUM_OEU-1:0] oeu_late,
  input wire logic [NUM_ISU-1:0] isu_event,
  // unit controls
  output logic [NUM_OEU-1:0] oeu_enable,
  output logic [NUM_OEU-1:0] oeu_notify,
  output logic [NUM_ISU-1:0] isu_irq_enable,
  output logic pin_event_irq
);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic acc;
  logic wr;
  logic in_map;
  logic [NUM_OEU-1:0] oeu_sel;
  logic [NUM_ISU-1:0] isu_sel;
  logic stamp_ptr_r;
  logic [1:0] oeu_ptr_r;
  logic [NUM_OEU-1:0] err_r;
  logic [NUM_OEU-1:0] done_r;
  logic [NUM_OEU-1:0] oeu_irq_r;
  logic [NUM_ISU-1:0] isu_irq_r;
  logic [NUM_OEU-1:0] en_r;
  logic [NUM_OEU-1:0] notify_r;
  logic [NUM_ISU-1:0] isu_ie_r;
  logic [NUM_OEU-1:0] en_cleared;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign in_map = (paddr == OFF_INDEX) || (paddr == OFF_DONE_ERR) ||
                  (paddr == OFF_IRQ_STAT) || (paddr == OFF_STAMP_CTRL) ||
                  (paddr == OFF_NOTIFY);
  assign pslverr = acc && !in_map;

  // ************************************************************
  // unit index
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_ptr_r <= STAMP_PTR_RST;
      oeu_ptr_r <= OEU_PTR_RST;
    end else if (wr && paddr == OFF_INDEX) begin
      stamp_ptr_r <= pwdata[POS_STAMP_PTR];
      // reserved code is kept out so no phantom unit is ever addressed
      if (pwdata[POS_OEU_PTR+:2] != OEU_PTR_RESERVED) begin
        oeu_ptr_r <= pwdata[POS_OEU_PTR+:2];
      end
    end
  end

  // ************************************************************
  // per-unit controls in the indexed range
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OEU; gi++) begin : g_oeu
      assign oeu_sel[gi] = (oeu_ptr_r == 2'(gi));
      assign en_cleared[gi] = wr && oeu_sel[gi] &&
        paddr == OFF_STAMP_CTRL && !pwdata[POS_OEU_EN];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          en_r[gi] <= 1'b0;
          notify_r[gi] <= 1'b0;
        end else begin
          if (oeu_fired[gi]) begin
            en_r[gi] <= 1'b0;
          end else if (wr && oeu_sel[gi] && paddr == OFF_STAMP_CTRL) begin
            en_r[gi] <= pwdata[POS_OEU_EN];
          end
          if (wr && oeu_sel[gi] && paddr == OFF_NOTIFY) begin
            notify_r[gi] <= pwdata[POS_NOTIFY];
          end
        end
      end
      // status flags: set beats clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          err_r[gi] <= 1'b0;
          done_r[gi] <= 1'b0;
          oeu_irq_r[gi] <= 1'b0;
        end else begin
          if (oeu_late[gi] && notify_r[gi]) begin
            err_r[gi] <= 1'b1;
          end else if ((wr && paddr == OFF_DONE_ERR &&
                        pwdata[POS_ERR+gi]) || en_cleared[gi]) begin
            err_r[gi] <= 1'b0;
          end
          if (oeu_fired[gi] && notify_r[gi]) begin
            done_r[gi] <= 1'b1;
          end else if (wr && paddr == OFF_DONE_ERR && pwdata[POS_DONE+gi]) begin
            done_r[gi] <= 1'b0;
          end
          if ((oeu_late[gi] || oeu_fired[gi]) && notify_r[gi]) begin
            oeu_irq_r[gi] <= 1'b1;
          end else if (wr && paddr == OFF_IRQ_STAT &&
                       pwdata[POS_OEU_IRQ+gi]) begin
            oeu_irq_r[gi] <= 1'b0;
          end
        end
      end
    end
    for (gi = 0; gi < NUM_ISU; gi++) begin : g_isu
      assign isu_sel[gi] = (stamp_ptr_r == 1'(gi));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          isu_ie_r[gi] <= 1'b0;
          isu_irq_r[gi] <= 1'b0;
        end else begin
          if (wr && isu_sel[gi] && paddr == OFF_STAMP_CTRL) begin
            isu_ie_r[gi] <= pwdata[POS_STAMP_IRQ_EN];
          end
          if (isu_event[gi] && isu_ie_r[gi]) begin
            isu_irq_r[gi] <= 1'b1;
          end else if (wr && paddr == OFF_IRQ_STAT &&
                       pwdata[POS_ISU_IRQ+gi]) begin
            isu_irq_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign oeu_enable = en_r;
  assign oeu_notify = notify_r;
  assign isu_irq_enable = isu_ie_r;
  // the global bit is purely combinational so it drops with the last clear
  assign pin_event_irq = (|oeu_irq_r) || (|isu_irq_r);

  // ************************************************************
  // read mux
  // ************************************************************
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = ZERO_WORD;
    if (paddr == OFF_INDEX) begin
      rd_nxt[POS_STAMP_PTR] = stamp_ptr_r;
      rd_nxt[POS_OEU_PTR+:2] = oeu_ptr_r;
    end else if (paddr == OFF_DONE_ERR) begin
      rd_nxt[POS_ERR+:NUM_OEU] = err_r;
      rd_nxt[POS_DONE+:NUM_OEU] = done_r;
    end else if (paddr == OFF_IRQ_STAT) begin
      rd_nxt[POS_OEU_IRQ+:NUM_OEU] = oeu_irq_r;
      rd_nxt[POS_ISU_IRQ+:NUM_ISU] = isu_irq_r;
    end else if (paddr == OFF_STAMP_CTRL) begin
      rd_nxt[POS_OEU_EN] = |(en_r & oeu_sel);
      rd_nxt[POS_STAMP_IRQ_EN] = |(isu_ie_r & isu_sel);
    end else if (paddr == OFF_NOTIFY) begin
      rd_nxt[POS_NOTIFY] = |(notify_r & oeu_sel);
    end
  end

  // read data is registered during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ZERO_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ptr_no_reserved: assert property (oeu_ptr_r != OEU_PTR_RESERVED)
    else $error("output-event pointer holds reserved code");
  a_stamp_ptr_write: assert property (wr && paddr == OFF_INDEX |=>
    stamp_ptr_r == $past(pwdata[POS_STAMP_PTR]))
    else $error("stamp pointer did not take write");
  a_err_set: assert property (oeu_late[0] && notify_r[0] |=> err_r[0])
    else $error("late error not set");
  a_err_clear_en: assert property (en_cleared[1] && !oeu_late[1] |=>
    !err_r[1])
    else $error("late error not cleared by enable write");
  a_done_set: assert property (oeu_fired[2] && notify_r[2] |=>
    done_r[2] && !en_r[2])
    else $error("done flag or enable wrong after event");
  a_irq_or: assert property ($rose(oeu_irq_r[0]) |-> pin_event_irq)
    else $error("global irq not raised");
  a_isu_gate: assert property (!isu_ie_r[0] && !isu_irq_r[0] |=>
    !isu_irq_r[0])
    else $error("stamp irq set while disabled");
  a_notify_only: assert property (!notify_r[1] && !oeu_irq_r[1] |=>
    !oeu_irq_r[1])
    else $error("output-event irq set without notify");
  a_set_wins: assert property (oeu_fired[0] && notify_r[0] && wr &&
    paddr == OFF_DONE_ERR && pwdata[POS_DONE] |=> done_r[0])
    else $error("clear beat hardware set");
  a_other_untouched: assert property (wr && paddr == OFF_NOTIFY &&
    !oeu_sel[2] |=> notify_r[2] == $past(notify_r[2]))
    else $error("unselected unit changed");

  // ************************************************************
  // clear paths and unselected units
  // ************************************************************
  // a mis-indexed write or a lost clear would otherwise only show up
  // when software happens to read the very unit that went wrong

  a_slverr_mapped: assert property (
    acc && paddr == OFF_INDEX |-> !pslverr)
    else $error("error response on a mapped register");

  a_oeu_ptr_write: assert property (
    wr && paddr == OFF_INDEX &&
    pwdata[POS_OEU_PTR+:2] != OEU_PTR_RESERVED |=>
    oeu_ptr_r == $past(pwdata[POS_OEU_PTR+:2]))
    else $error("output-event pointer did not take write");

  a_ptr_rsvd_kept: assert property (
    wr && paddr == OFF_INDEX &&
    pwdata[POS_OEU_PTR+:2] == OEU_PTR_RESERVED |=> $stable(oeu_ptr_r))
    else $error("reserved pointer code changed the pointer");

  a_index_read: assert property (
    psel && !penable && !pwrite && paddr == OFF_INDEX |=>
    prdata[POS_STAMP_PTR] == $past(stamp_ptr_r))
    else $error("stamp pointer read back wrong");

  a_err_w1c: assert property (
    wr && paddr == OFF_DONE_ERR && pwdata[POS_ERR+1] &&
    !oeu_late[1] |=> !err_r[1])
    else $error("late error not cleared by written one");

  a_done_w1c: assert property (
    wr && paddr == OFF_DONE_ERR && pwdata[POS_DONE+2] &&
    !oeu_fired[2] |=> !done_r[2])
    else $error("done flag not cleared by written one");

  a_err_zero_keep: assert property (
    err_r[2] && !en_cleared[2] &&
    !(wr && paddr == OFF_DONE_ERR && pwdata[POS_ERR+2]) |=> err_r[2])
    else $error("late error lost without a clear");

  a_irq_late_set: assert property (
    oeu_late[2] && notify_r[2] |=> oeu_irq_r[2])
    else $error("late event raised no interrupt");

  a_irq_w1c: assert property (
    wr && paddr == OFF_IRQ_STAT && pwdata[POS_OEU_IRQ+2] &&
    !((oeu_late[2] || oeu_fired[2]) && notify_r[2]) |=> !oeu_irq_r[2])
    else $error("output-event irq not cleared by write");

  a_isu_set: assert property (
    isu_event[1] && isu_ie_r[1] |=> isu_irq_r[1])
    else $error("stamp irq not set");

  a_isu_set_wins: assert property (
    isu_event[1] && isu_ie_r[1] && wr && paddr == OFF_IRQ_STAT &&
    pwdata[POS_ISU_IRQ+1] |=> isu_irq_r[1])
    else $error("stamp irq clear beat hardware set");

  a_irq_quiet: assert property (
    !(|oeu_irq_r) && !(|isu_irq_r) |-> !pin_event_irq)
    else $error("global irq high with no status bit");

  a_en_self_clear: assert property (
    oeu_fired[0] |=> !en_r[0])
    else $error("unit enable did not clear on event");

  a_en_write: assert property (
    wr && oeu_sel[2] && paddr == OFF_STAMP_CTRL && !oeu_fired[2] |=>
    en_r[2] == $past(pwdata[POS_OEU_EN]))
    else $error("selected unit enable did not take write");

  a_isu_ie_other: assert property (
    wr && paddr == OFF_STAMP_CTRL && !isu_sel[0] |=> $stable(isu_ie_r[0]))
    else $error("unselected stamp unit enable changed");

  a_isu_ie_write: assert property (
    wr && isu_sel[1] && paddr == OFF_STAMP_CTRL |=>
    isu_ie_r[1] == $past(pwdata[POS_STAMP_IRQ_EN]))
    else $error("stamp irq enable did not take write");


  c_done: cover property (oeu_fired[0] && notify_r[0]);
  c_late: cover property (oeu_late[1] && notify_r[1]);
  c_isu: cover property (isu_event[1] && isu_ie_r[1]);
  c_irq_clear: cover property ($fell(pin_event_irq));
  c_set_on_clear: cover property (isu_event[1] && isu_ie_r[1] && wr &&
    paddr == OFF_IRQ_STAT);

endmodule : ptpidx_bank

// File: verification/tb_top.sv
// self-checking apb bench for the ptp unit index and status bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ptpidx_pkg::*;
  // ****************
  // design and stimulus
  // ****************
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, pin_event_irq, erq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = ZERO_WORD, prdata, rd;
  logic [2:0] oeu_fired = 3'h0, oeu_late = 3'h0, oeu_enable, oeu_notify;
  logic [1:0] isu_event = 2'h0, isu_irq_enable;
  int n_errors = 0, n_tests = 0;
  ptpidx_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oeu_fired(oeu_fired), .oeu_late(oeu_late), .isu_event(isu_event),
    .oeu_enable(oeu_enable), .oeu_notify(oeu_notify),
    .isu_irq_enable(isu_irq_enable), .pin_event_irq(pin_event_irq));
  initial forever #50 pclk = ~pclk;
  // ****************
  // shared tasks
  // ****************
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // ev pulses the stamp events on the edge that takes the transfer
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [1:0] ev);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1; isu_event <= ev;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      give_verdict();
    end
    rd = prdata; erq = pslverr;
    psel <= 1'b0; penable <= 1'b0; isu_event <= 2'h0;
    @(negedge pclk);
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, ZERO_WORD, 2'h0);
    chk(rd, exp);
  endtask : rchk
  task automatic pulse(input logic [2:0] fo, la, input logic [1:0] ie);
    @(posedge pclk);
    oeu_fired <= fo; oeu_late <= la; isu_event <= ie;
    @(posedge pclk);
    oeu_fired <= 3'h0; oeu_late <= 3'h0; isu_event <= 2'h0;
    @(negedge pclk);
  endtask : pulse
  // ****************
  // scenarios
  // ****************
  task automatic t_index();
    rchk(OFF_INDEX, ZERO_WORD);
    chk({31'h0, erq}, ZERO_WORD);
    rchk(OFF_DONE_ERR, ZERO_WORD);
    rchk(OFF_IRQ_STAT, ZERO_WORD);
    apb(1'b1, OFF_INDEX, 32'hFFFF_FFFE, 2'h0);
    rchk(OFF_INDEX, 32'h0000_0102);
    apb(1'b1, OFF_INDEX, 32'h0000_0003, 2'h0);
    rchk(OFF_INDEX, 32'h0000_0002);
  endtask : t_index
  task automatic t_ctrl();
    apb(1'b1, OFF_INDEX, 32'h0000_0102, 2'h0);
    apb(1'b1, OFF_STAMP_CTRL, 32'hFFFF_FFFF, 2'h0);
    chk({29'h0, oeu_enable}, 32'h0000_0004);
    chk({30'h0, isu_irq_enable}, 32'h0000_0002);
    rchk(OFF_STAMP_CTRL, 32'h0000_0028);
    apb(1'b1, OFF_NOTIFY, 32'h0000_0001, 2'h0);
    chk({29'h0, oeu_notify}, 32'h0000_0004);
    apb(1'b1, OFF_INDEX, ZERO_WORD, 2'h0);
    rchk(OFF_STAMP_CTRL, ZERO_WORD);
    apb(1'b1, OFF_INDEX, 32'h0000_0102, 2'h0);
  endtask : t_ctrl
  task automatic t_flags();
    pulse(3'h0, 3'h5, 2'h0);
    rchk(OFF_DONE_ERR, 32'h0004_0000);
    rchk(OFF_IRQ_STAT, 32'h0004_0000);
    chk({31'h0, pin_event_irq}, 32'h0000_0001);
    apb(1'b1, OFF_DONE_ERR, ZERO_WORD, 2'h0);
    rchk(OFF_DONE_ERR, 32'h0004_0000);
    pulse(3'h4, 3'h0, 2'h0);
    rchk(OFF_DONE_ERR, 32'h0004_0004);
    chk({29'h0, oeu_enable}, ZERO_WORD);
    apb(1'b1, OFF_DONE_ERR, 32'h0000_0004, 2'h0);
    rchk(OFF_DONE_ERR, 32'h0004_0000);
    apb(1'b1, OFF_STAMP_CTRL, 32'h0000_0028, 2'h0);
    apb(1'b1, OFF_STAMP_CTRL, 32'h0000_0020, 2'h0);
    rchk(OFF_DONE_ERR, ZERO_WORD);
    rchk(OFF_IRQ_STAT, 32'h0004_0000);
    apb(1'b1, OFF_IRQ_STAT, 32'h0004_0000, 2'h0);
    rchk(OFF_IRQ_STAT, ZERO_WORD);
    chk({31'h0, pin_event_irq}, ZERO_WORD);
  endtask : t_flags
  task automatic t_stamp();
    pulse(3'h0, 3'h0, 2'h3);
    rchk(OFF_IRQ_STAT, 32'h0000_0002);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_0002, 2'h2);
    rchk(OFF_IRQ_STAT, 32'h0000_0002);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_0002, 2'h0);
    rchk(OFF_IRQ_STAT, ZERO_WORD);
  endtask : t_stamp
  task automatic t_unmapped();
    apb(1'b1, 12'h600, 32'hFFFF_FFFF, 2'h0);
    rchk(12'h600, ZERO_WORD);
    chk({31'h0, erq}, 32'h0000_0001);
  endtask : t_unmapped
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_index();
    t_ctrl();
    t_flags();
    t_stamp();
    t_unmapped();
    give_verdict();
  end
endmodule : tb_top
